// >>> logic/tw_cmp_out.sv
module tw_cmp_out import tw_pkg::*; #(
  parameter bit IS_A = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // configuration
  input wire logic [1:0] com,
  input wire tw_class_t cls,
  input wire logic wgm3,
  // timer events
  input wire logic match,
  input wire logic top_hit,
  input wire logic up,
  input wire logic force_cmp,
  // port side
  input wire logic port_data,
  input wire logic port_dir,
  output tw_pin_t pin
);
  typedef struct packed {
    logic oc;
    tw_pin_t pin;
  } tw_cmp_state_t;

  tw_cmp_state_t s_r;
  tw_cmp_state_t s_nxt;
  logic toggle_ok;
  logic connect;

  always_comb begin
    s_nxt = s_r;
    toggle_ok = (cls == CLS_NONPWM) || (IS_A && wgm3);
    connect = (com != COM_OFF) && !((com == COM_TOGGLE) && !toggle_ok);
    case (cls)
      CLS_NONPWM: begin
        if (match || force_cmp) begin
          case (com)
            COM_TOGGLE: s_nxt.oc = ~s_r.oc;
            COM_CLEAR: s_nxt.oc = 1'b0;
            COM_SET: s_nxt.oc = 1'b1;
            default: s_nxt.oc = s_r.oc;
          endcase
        end
      end
      CLS_FAST: begin
        if (top_hit && com[1]) begin
          s_nxt.oc = (com == COM_CLEAR);
        end else if (match) begin
          case (com)
            COM_TOGGLE: s_nxt.oc = toggle_ok ? ~s_r.oc : s_r.oc;
            COM_CLEAR: s_nxt.oc = 1'b0;
            COM_SET: s_nxt.oc = 1'b1;
            default: s_nxt.oc = s_r.oc;
          endcase
        end
      end
      CLS_DUAL: begin
        if (match) begin
          case (com)
            COM_TOGGLE: s_nxt.oc = toggle_ok ? ~s_r.oc : s_r.oc;
            COM_CLEAR: s_nxt.oc = ~up;
            COM_SET: s_nxt.oc = up;
            default: s_nxt.oc = s_r.oc;
          endcase
        end
      end
      default: s_nxt.oc = s_r.oc;
    endcase
    s_nxt.pin.oe = port_dir;
    s_nxt.pin.o = connect ? s_nxt.oc : port_data;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin = s_r.pin;
endmodule // tw_cmp_out

// >>> logic/tw_pkg.sv
package tw_pkg;
  localparam logic [3:0] ADDR_CTL_A = 4'h0;
  localparam logic [3:0] ADDR_CTL_B = 4'h1;
  localparam logic [3:0] ADDR_CTL_C = 4'h2;
  localparam logic [3:0] ADDR_CNT_LO = 4'h3;
  localparam logic [3:0] ADDR_CNT_HI = 4'h4;
  localparam logic [3:0] ADDR_OCA_LO = 4'h5;
  localparam logic [3:0] ADDR_OCA_HI = 4'h6;
  localparam logic [3:0] ADDR_OCB_LO = 4'h7;
  localparam logic [3:0] ADDR_OCB_HI = 4'h8;
  localparam logic [3:0] ADDR_ICR_LO = 4'h9;
  localparam logic [3:0] ADDR_ICR_HI = 4'ha;
  localparam logic [3:0] ADDR_FLAGS = 4'hb;
  localparam logic [3:0] ADDR_PIN_DIR = 4'hc;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam int CA_COM_A = 6;
  localparam int CA_COM_B = 4;
  localparam int CA_WGM = 0;
  localparam int CB_NOISE = 7;
  localparam int CB_EDGE = 6;
  localparam int CB_WGM = 3;
  localparam int CB_CS = 0;
  localparam int CC_FORCE_A = 7;
  localparam int CC_FORCE_B = 6;
  localparam int FLG_TOV = 0;
  localparam int FLG_OCFA = 1;
  localparam int FLG_OCFB = 2;
  localparam int FLG_ICF = 3;
  localparam int DIR_A = 0;
  localparam int DIR_B = 1;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_CTC_OCR = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PFC_ICR = 4'h8;
  localparam logic [3:0] MODE_PFC_OCR = 4'h9;
  localparam logic [3:0] MODE_PC_ICR = 4'ha;
  localparam logic [3:0] MODE_PC_OCR = 4'hb;
  localparam logic [3:0] MODE_CTC_ICR = 4'hc;
  localparam logic [3:0] MODE_FAST_ICR = 4'he;
  localparam logic [3:0] MODE_FAST_OCR = 4'hf;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  typedef enum logic [1:0] {CLS_NONPWM, CLS_FAST, CLS_DUAL} tw_class_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tw_req_t;
  typedef struct packed {
    logic o;
    logic oe;
  } tw_pin_t;
endpackage

// >>> logic/tw_timer16.sv
module tw_timer16 import tw_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire tw_req_t req,
  output logic [7:0] rdata,
  // pins in
  input wire logic ext_clk_pin,
  input wire logic capture_pin,
  // normal port values
  input wire logic port_data_a,
  input wire logic port_data_b,
  // compare outputs
  output tw_pin_t compare_out_a,
  output tw_pin_t compare_out_b
);
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] wgm_lo;
    logic noise;
    logic edge_rise;
    logic [1:0] wgm_hi;
    logic [2:0] cs;
    logic [15:0] cnt;
    logic dir_down;
    logic [15:0] ocr_a;
    logic [15:0] ocr_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] icr;
    logic [3:0] flags;
    logic [1:0] dir;
    logic [9:0] pre;
    logic [2:0] t1_s;
    logic [2:0] icp_s;
    logic block;
    logic [7:0] rdata;
  } tw_state_t;

  tw_state_t s_r;
  tw_state_t s_nxt;
  logic [3:0] mode;
  logic [15:0] top;
  tw_class_t cls;
  logic upd_imm;
  logic upd_bot;
  logic icr_top;
  logic tick;
  logic top_hit;
  logic bot_hit;
  logic max_hit;
  logic match_a;
  logic match_b;
  logic upd_now;
  logic cap_evt;
  logic [3:0] flg_set;
  logic [3:0] flg_clr;
  logic force_a;
  logic force_b;
  logic wr;

  always_comb begin
    s_nxt = s_r;
    wr = req.wr;
    mode = {s_r.wgm_hi, s_r.wgm_lo};
    top = TOP_MAX;
    cls = CLS_NONPWM;
    upd_imm = 1'b1;
    upd_bot = 1'b0;
    icr_top = 1'b0;
    case (mode)
      MODE_NORMAL: top = TOP_MAX;
      MODE_PC8, MODE_PC9, MODE_PC10: begin
        top = (mode == MODE_PC8) ? TOP_8 : (mode == MODE_PC9) ? TOP_9 : TOP_10;
        cls = CLS_DUAL;
        upd_imm = 1'b0;
      end
      MODE_CTC_OCR: top = s_r.ocr_a;
      MODE_CTC_ICR: begin
        top = s_r.icr;
        icr_top = 1'b1;
      end
      MODE_FAST8, MODE_FAST9, MODE_FAST10: begin
        top = (mode == MODE_FAST8) ? TOP_8 : (mode == MODE_FAST9) ? TOP_9 : TOP_10;
        cls = CLS_FAST;
        upd_imm = 1'b0;
      end
      MODE_FAST_ICR, MODE_FAST_OCR: begin
        icr_top = (mode == MODE_FAST_ICR);
        top = icr_top ? s_r.icr : s_r.ocr_a;
        cls = CLS_FAST;
        upd_imm = 1'b0;
      end
      MODE_PFC_ICR, MODE_PFC_OCR: begin
        icr_top = (mode == MODE_PFC_ICR);
        top = icr_top ? s_r.icr : s_r.ocr_a;
        cls = CLS_DUAL;
        upd_imm = 1'b0;
        upd_bot = 1'b1;
      end
      MODE_PC_ICR, MODE_PC_OCR: begin
        icr_top = (mode == MODE_PC_ICR);
        top = icr_top ? s_r.icr : s_r.ocr_a;
        cls = CLS_DUAL;
        upd_imm = 1'b0;
      end
      default: top = TOP_MAX;
    endcase

    // clock source and prescaler
    s_nxt.pre = s_r.pre + 10'h001;
    s_nxt.t1_s = {s_r.t1_s[1:0], ext_clk_pin};
    s_nxt.icp_s = {s_r.icp_s[1:0], capture_pin};
    case (s_r.cs)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (s_r.pre & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64: tick = (s_r.pre & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256: tick = (s_r.pre & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024: tick = s_r.pre == PRE_MASK_1024;
      CS_EXT_FALL: tick = !s_r.t1_s[1] && s_r.t1_s[2];
      CS_EXT_RISE: tick = s_r.t1_s[1] && !s_r.t1_s[2];
      default: tick = 1'b0;
    endcase

    // counter events, all qualified by the tick
    top_hit = tick && (s_r.cnt == top);
    bot_hit = tick && (cls == CLS_DUAL) && (s_r.cnt == BOTTOM) && s_r.dir_down;
    max_hit = tick && (s_r.cnt == TOP_MAX);
    match_a = tick && !s_r.block && (s_r.cnt == s_r.ocr_a);
    match_b = tick && !s_r.block && (s_r.cnt == s_r.ocr_b);
    if (tick) begin
      s_nxt.block = 1'b0;
      if (cls == CLS_DUAL) begin
        if (!s_r.dir_down) begin
          if (s_r.cnt >= top) begin
            s_nxt.dir_down = 1'b1;
            s_nxt.cnt = s_r.cnt - 16'h0001;
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end else if (s_r.cnt == BOTTOM) begin
          s_nxt.dir_down = 1'b0;
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end else begin
        s_nxt.dir_down = 1'b0;
        s_nxt.cnt = (s_r.cnt == top) ? BOTTOM : s_r.cnt + 16'h0001;
      end
    end

    // input capture
    cap_evt = !icr_top && (s_r.edge_rise ? (s_r.icp_s[1] && !s_r.icp_s[2]) :
                           (!s_r.icp_s[1] && s_r.icp_s[2]));

    // register writes
    flg_clr = 4'h0;
    force_a = 1'b0;
    force_b = 1'b0;
    if (wr) begin
      case (req.addr)
        ADDR_CTL_A: begin
          s_nxt.com_a = req.wdata[CA_COM_A +: 2];
          s_nxt.com_b = req.wdata[CA_COM_B +: 2];
          s_nxt.wgm_lo = req.wdata[CA_WGM +: 2];
        end
        ADDR_CTL_B: begin
          s_nxt.noise = req.wdata[CB_NOISE];
          s_nxt.edge_rise = req.wdata[CB_EDGE];
          s_nxt.wgm_hi = req.wdata[CB_WGM +: 2];
          s_nxt.cs = req.wdata[CB_CS +: 3];
        end
        ADDR_CTL_C: begin
          force_a = req.wdata[CC_FORCE_A] && (cls == CLS_NONPWM);
          force_b = req.wdata[CC_FORCE_B] && (cls == CLS_NONPWM);
        end
        ADDR_CNT_LO: begin
          s_nxt.cnt[7:0] = req.wdata;
          s_nxt.block = 1'b1;
        end
        ADDR_CNT_HI: begin
          s_nxt.cnt[15:8] = req.wdata;
          s_nxt.block = 1'b1;
        end
        ADDR_OCA_LO: s_nxt.buf_a[7:0] = req.wdata;
        ADDR_OCA_HI: s_nxt.buf_a[15:8] = req.wdata;
        ADDR_OCB_LO: s_nxt.buf_b[7:0] = req.wdata;
        ADDR_OCB_HI: s_nxt.buf_b[15:8] = req.wdata;
        ADDR_ICR_LO: s_nxt.icr[7:0] = req.wdata;
        ADDR_ICR_HI: s_nxt.icr[15:8] = req.wdata;
        ADDR_FLAGS: flg_clr = req.wdata[3:0];
        ADDR_PIN_DIR: s_nxt.dir = req.wdata[1:0];
        default: s_nxt.dir = s_r.dir;
      endcase
    end
    if (cap_evt) begin
      s_nxt.icr = s_r.cnt;
    end

    // compare buffer transfer
    upd_now = upd_bot ? bot_hit : top_hit;
    if (upd_imm) begin
      s_nxt.ocr_a = s_nxt.buf_a;
      s_nxt.ocr_b = s_nxt.buf_b;
    end else if (upd_now) begin
      s_nxt.ocr_a = s_r.buf_a;
      s_nxt.ocr_b = s_r.buf_b;
    end

    // flags, set wins over clear
    flg_set = 4'h0;
    case (cls)
      CLS_NONPWM: flg_set[FLG_TOV] = max_hit;
      CLS_FAST: flg_set[FLG_TOV] = top_hit;
      CLS_DUAL: flg_set[FLG_TOV] = bot_hit;
      default: flg_set[FLG_TOV] = 1'b0;
    endcase
    flg_set[FLG_OCFA] = match_a;
    flg_set[FLG_OCFB] = match_b;
    flg_set[FLG_ICF] = cap_evt || (icr_top && top_hit);
    s_nxt.flags = (s_r.flags & ~flg_clr) | flg_set;

    // read data, valid the cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ADDR_CTL_A: s_nxt.rdata = {s_r.com_a, s_r.com_b, 2'b00, s_r.wgm_lo};
        ADDR_CTL_B: s_nxt.rdata = {s_r.noise, s_r.edge_rise, 1'b0, s_r.wgm_hi, s_r.cs};
        ADDR_CNT_LO: s_nxt.rdata = s_r.cnt[7:0];
        ADDR_CNT_HI: s_nxt.rdata = s_r.cnt[15:8];
        ADDR_OCA_LO: s_nxt.rdata = s_r.buf_a[7:0];
        ADDR_OCA_HI: s_nxt.rdata = s_r.buf_a[15:8];
        ADDR_OCB_LO: s_nxt.rdata = s_r.buf_b[7:0];
        ADDR_OCB_HI: s_nxt.rdata = s_r.buf_b[15:8];
        ADDR_ICR_LO: s_nxt.rdata = s_r.icr[7:0];
        ADDR_ICR_HI: s_nxt.rdata = s_r.icr[15:8];
        ADDR_FLAGS: s_nxt.rdata = {4'h0, s_r.flags};
        ADDR_PIN_DIR: s_nxt.rdata = {6'h00, s_r.dir};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.com_a <= CTL_RST[CA_COM_A +: 2];
      s_r.cnt <= VAL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  tw_cmp_out #(.IS_A(1'b1)) u_chan_a (
    .clk(clk),
    .srst(srst),
    .com(s_r.com_a),
    .cls(cls),
    .wgm3(s_r.wgm_hi[1]),
    .match(match_a),
    .top_hit(top_hit),
    .up(!s_r.dir_down),
    .force_cmp(force_a),
    .port_data(port_data_a),
    .port_dir(s_r.dir[DIR_A]),
    .pin(compare_out_a)
  );

  tw_cmp_out #(.IS_A(1'b0)) u_chan_b (
    .clk(clk),
    .srst(srst),
    .com(s_r.com_b),
    .cls(cls),
    .wgm3(s_r.wgm_hi[1]),
    .match(match_b),
    .top_hit(top_hit),
    .up(!s_r.dir_down),
    .force_cmp(force_b),
    .port_data(port_data_b),
    .port_dir(s_r.dir[DIR_B]),
    .pin(compare_out_b)
  );

  assign rdata = s_r.rdata;
endmodule // tw_timer16

// >>> testbench/tb_tw_timer16.sv
module tb_tw_timer16 import tw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  tw_req_t req = '0;
  logic [7:0] rdata;
  logic port_data_a = 1'b0;
  logic port_data_b = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic capture_pin = 1'b0;
  tw_pin_t compare_out_a;
  tw_pin_t compare_out_b;
  logic [7:0] rd_val;
  int failures = 0;
  int tests_run = 0;

  tw_timer16 u_tw_timer16 (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
    .ext_clk_pin(ext_clk_pin), .capture_pin(capture_pin), .port_data_a(port_data_a),
    .port_data_b(port_data_b), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b));

  always #20 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one bus cycle, read data captured into rd_val
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1 rd_val = rdata;
  endtask

  function automatic logic pin(input logic ch);
    return ch ? compare_out_b.o : compare_out_a.o;
  endfunction

  task automatic run_len(input logic ch, input logic v, input int lim, output int n);
    n = 0;
    while (pin(ch) === v && n < lim) begin
      wait_cyc(1);
      n++;
    end
  endtask

  task automatic setup(input logic [3:0] m, input logic [2:0] cs, input logic [1:0] ca,
      input logic [1:0] cb, input logic [7:0] oa, input logic [7:0] ob, input logic [7:0] ic);
    bus(1'b1, ADDR_CTL_B, 8'h00);
    bus(1'b1, ADDR_CTL_A, {ca, cb, 2'b00, m[1:0]});
    bus(1'b1, ADDR_OCA_LO, oa);
    bus(1'b1, ADDR_OCB_LO, ob);
    bus(1'b1, ADDR_ICR_LO, ic);
    bus(1'b1, ADDR_CNT_LO, 8'h00);
    bus(1'b1, ADDR_FLAGS, 8'h0f);
    bus(1'b1, ADDR_CTL_B, {3'b000, m[3:2], cs});
  endtask

  task automatic t_regs();
    for (int a = 0; a < 16; a++) begin
      bus(1'b0, 4'(a), 8'h00);
      check(rd_val, 8'h00);
    end
    bus(1'b1, ADDR_CTL_A, 8'hff);
    bus(1'b0, ADDR_CTL_A, 8'h00);
    check(rd_val, 8'hf3);
    bus(1'b1, ADDR_CTL_B, 8'hff);
    bus(1'b0, ADDR_CTL_B, 8'h00);
    check(rd_val, 8'hdf);
    bus(1'b1, ADDR_CTL_B, 8'h00);
    bus(1'b1, ADDR_CTL_A, 8'h00);
    bus(1'b1, 4'hf, 8'hff);
    bus(1'b0, 4'hf, 8'h00);
    check(rd_val, 8'h00);
    bus(1'b1, ADDR_PIN_DIR, 8'h01);
    wait_cyc(3);
    check({compare_out_a.oe, compare_out_b.oe}, 2'b10);
    bus(1'b1, ADDR_PIN_DIR, 8'h03);
    wait_cyc(3);
    check({compare_out_a.oe, compare_out_b.oe}, 2'b11);
  endtask

  // forced matches in normal mode: set, clear, toggle twice
  task automatic t_force();
    logic [1:0] codes [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_TOGGLE};
    logic [3:0] exps = 4'b0101;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTL_A, {codes[i], codes[i], 4'h0});
      bus(1'b1, ADDR_CTL_C, 8'hc0);
      wait_cyc(3);
      check({compare_out_a.o, compare_out_b.o}, {2{exps[i]}});
    end
  endtask

  task automatic t_disc(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb);
    setup(m, CS_DIV1, ca, cb, 8'h10, 8'h10, 8'h30);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      port_data_a <= v[0];
      port_data_b <= v[0];
      wait_cyc(3);
      check({compare_out_a.o, compare_out_b.o}, {2{v[0]}});
    end
  endtask

  task automatic pwm(input logic [3:0] m, input logic [2:0] cs, input logic [1:0] ca,
      input logic [1:0] cb, input logic [7:0] oa, input logic [7:0] ob, input logic [7:0] ic,
      input logic ch, input int hi, input int lo, input logic tov);
    int lim;
    int h;
    int l;
    lim = 2 * (hi + lo) + 200;
    setup(m, cs, ca, cb, oa, ob, ic);
    wait_cyc(lim);
    run_len(ch, 1'b1, lim, h);
    run_len(ch, 1'b0, lim, l);
    run_len(ch, 1'b1, lim, h);
    run_len(ch, 1'b0, lim, l);
    check(16'(h), 16'(hi));
    check(16'(l), 16'(lo));
    bus(1'b0, ADDR_FLAGS, 8'h00);
    check(rd_val[FLG_TOV], tov);
  endtask

  // external clock: five rising then three falling edges
  task automatic t_ext();
    setup(MODE_NORMAL, CS_EXT_RISE, COM_OFF, COM_OFF, 8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      if (i == 5)
        bus(1'b1, ADDR_CTL_B, {5'h00, CS_EXT_FALL});
      @(posedge clk);
      ext_clk_pin <= 1'b1;
      wait_cyc(4);
      @(posedge clk);
      ext_clk_pin <= 1'b0;
      wait_cyc(5);
    end
    bus(1'b0, ADDR_CNT_LO, 8'h00);
    check(rd_val, 8'h08);
  endtask

  // one rise and one fall on the capture pin
  task automatic pulse_cap();
    @(posedge clk);
    capture_pin <= 1'b1;
    wait_cyc(4);
    @(posedge clk);
    capture_pin <= 1'b0;
    wait_cyc(5);
  endtask

  // falling edge captures a stopped counter, ignored when capture is top
  task automatic t_capture();
    setup(MODE_NORMAL, CS_STOP, COM_OFF, COM_OFF, 8'h00, 8'h00, 8'h00);
    bus(1'b1, ADDR_CNT_LO, 8'h5a);
    pulse_cap();
    bus(1'b0, ADDR_ICR_LO, 8'h00);
    check(rd_val, 8'h5a);
    bus(1'b0, ADDR_FLAGS, 8'h00);
    check(rd_val, 8'h08);
    setup(MODE_CTC_ICR, CS_STOP, COM_OFF, COM_OFF, 8'h00, 8'h00, 8'h20);
    bus(1'b1, ADDR_CNT_LO, 8'h5a);
    pulse_cap();
    bus(1'b0, ADDR_ICR_LO, 8'h00);
    check(rd_val, 8'h20);
    bus(1'b0, ADDR_FLAGS, 8'h00);
    check(rd_val, 8'h00);
  endtask

  initial begin
    int n;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_force();
    t_disc(MODE_PC8, COM_TOGGLE, COM_TOGGLE);
    t_disc(MODE_PC_OCR, COM_OFF, COM_TOGGLE);
    setup(MODE_FAST8, CS_DIV1, COM_CLEAR, COM_OFF, 8'hff, 8'h00, 8'h00);
    wait_cyc(600);
    run_len(1'b0, 1'b1, 600, n);
    check(16'(n), 16'd600);
    pwm(MODE_FAST8, CS_DIV1, COM_CLEAR, COM_OFF, 8'h40, 8'h0, 8'h0, 0, 65, 191, 1);
    pwm(MODE_FAST8, CS_DIV1, COM_OFF, COM_SET, 8'h40, 8'h80, 8'h0, 1, 127, 129, 1);
    pwm(MODE_FAST_ICR, CS_DIV1, COM_CLEAR, COM_OFF, 8'h10, 8'h0, 8'h3f, 0, 17, 47, 1);
    pwm(MODE_FAST_OCR, CS_DIV1, COM_OFF, COM_CLEAR, 8'h3f, 8'h10, 8'h0, 1, 17, 47, 1);
    pwm(MODE_PC8, CS_DIV1, COM_CLEAR, COM_OFF, 8'h40, 8'h0, 8'h0, 0, 128, 382, 1);
    pwm(MODE_PC8, CS_DIV1, COM_SET, COM_OFF, 8'h40, 8'h0, 8'h0, 0, 382, 128, 1);
    for (int i = 8; i < 12; i++)
      pwm(4'(i), CS_DIV1, COM_OFF, COM_CLEAR, 8'h30, 8'h10, 8'h30, 1, 32, 64, 1);
    pwm(MODE_PC_OCR, CS_DIV1, COM_TOGGLE, COM_OFF, 8'h30, 8'h0, 8'h0, 0, 96, 96, 1);
    pwm(MODE_CTC_OCR, CS_DIV1, COM_TOGGLE, COM_OFF, 8'h20, 8'h0, 8'h0, 0, 33, 33, 0);
    pwm(MODE_CTC_ICR, CS_DIV1, COM_TOGGLE, COM_OFF, 8'h0, 8'h0, 8'h20, 0, 33, 33, 0);
    pwm(MODE_CTC_OCR, CS_DIV8, COM_TOGGLE, COM_OFF, 8'h20, 8'h0, 8'h0, 0, 264, 264, 0);
    t_ext();
    t_capture();
    wrap_up();
  end

  initial begin
    #(60000 * 40);
    failures++;
    wrap_up();
  end
endmodule // tb_tw_timer16

// >>> testbench/tw_timer16_asserts.sv
module tw_timer16_asserts import tw_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire tw_req_t req,
  input wire logic [7:0] rdata,
  // pins
  input wire logic ext_clk_pin,
  input wire logic capture_pin,
  input wire logic port_data_a,
  input wire logic port_data_b,
  input wire tw_pin_t compare_out_a,
  input wire tw_pin_t compare_out_b
);
  logic [3:0] com_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      com_r <= 4'h0;
    end else if (req.wr && req.addr == ADDR_CTL_A) begin
      com_r <= req.wdata[7:4];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_wr_rd(logic [3:0] a);
    (req.wr && req.addr == a) ##1 !req.wr ##1 (req.rd && req.addr == a);
  endsequence
  sequence s_dir_set;
    (req.wr && req.addr == ADDR_PIN_DIR) ##1 !req.wr;
  endsequence
  a_rdata_idle: assert property (!req.rd |=> rdata == 8'h00)
    else $error("read data not zero");
  a_ctl_a_rsvd: assert property (req.rd && req.addr == ADDR_CTL_A |=> rdata[3:2] == 2'b00)
    else $error("control a spare bits set");
  a_ctl_a_echo: assert property (s_wr_rd(ADDR_CTL_A) |=> rdata == ($past(req.wdata, 3) & 8'hf3))
    else $error("control a readback wrong");
  a_ctl_b_echo: assert property (s_wr_rd(ADDR_CTL_B) |=> rdata == ($past(req.wdata, 3) & 8'hdf))
    else $error("control b readback wrong");
  a_unmapped_zero: assert property (req.rd && (req.addr == ADDR_CTL_C || req.addr > ADDR_PIN_DIR)
    |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_dir_drive_a: assert property (s_dir_set |=> compare_out_a.oe == $past(req.wdata[DIR_A], 2))
    else $error("pin a enable wrong");
  a_dir_drive_b: assert property (s_dir_set |=> compare_out_b.oe == $past(req.wdata[DIR_B], 2))
    else $error("pin b enable wrong");
  a_port_pass_a: assert property (com_r[3:2] == 2'b00 && $past(com_r[3:2]) == 2'b00
    && $stable(port_data_a) && !$past(srst) |-> compare_out_a.o == port_data_a)
    else $error("pin a not port value");
  a_port_pass_b: assert property (com_r[1:0] == 2'b00 && $past(com_r[1:0]) == 2'b00
    && $stable(port_data_b) && !$past(srst) |-> compare_out_b.o == port_data_b)
    else $error("pin b not port value");
endmodule // tw_timer16_asserts

bind tw_timer16 tw_timer16_asserts u_tw_timer16_asserts (.clk(clk), .srst(srst), .req(req),
  .rdata(rdata), .ext_clk_pin(ext_clk_pin), .capture_pin(capture_pin),
  .port_data_a(port_data_a), .port_data_b(port_data_b), .compare_out_a(compare_out_a),
  .compare_out_b(compare_out_b));
